/* slf_regs.svh */
// Constants for the receive loss, framing and byte alignment block.
// Assumes inclusion by slf_pkg.sv, slf_rx_align.sv and the self-checking bench.
// Notes on behaviour
// RULE1 - No transition over 128 bit periods declares loss
// RULE2 - Sixteen transitions within 128-bit window clear loss
// RULE3 - Loss disable turns internal detector off
// RULE4 - External loss input is active low
// RULE5 - Loss without local loopback zeroes parallel output
// RULE6 - Local loopbacks prevent parallel output muting
// RULE7 - Remote loopback data muted on internal loss
// RULE8 - Remote loopback data muted while external loss low
// RULE9 - Loss disable never blocks external loss muting
// RULE10 - Serial mute touches only remote loopback path
// RULE11 - Pattern is three F6 then three 28
// RULE12 - Search runs while out-of-frame input high
// RULE13 - Found boundary assembles bytes for parallel output
// RULE14 - Frame pulse at third A2 on match
// RULE15 - Pulse lasts one byte clock, repeats per match
// RULE16 - Out-of-frame low freezes boundary, stops pulses
// RULE17 - Framer drops out-of-frame after confirming sync
// RULE18 - Eight serial bits de-interleave into one byte
// RULE19 - Rate select picks fast or quarter bit rate
// RULE20 - Byte launched on byte clock falling edge
// RULE21 - Byte clock is eight bit periods long
// RULE22 - Byte clock keeps running during loss
// RULE23 - Reset clears history, pulse low, arbitrary boundary
`ifndef SLF_REGS_SVH
`define SLF_REGS_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define SLF_CTRL_OFFSET    8'h00
`define SLF_STATUS_OFFSET  8'h04
`define SLF_CTRL_RESET     5'h10
`define SLF_CTRL_WIDTH     5
`define SLF_STATUS_WIDTH   5

// ----------------------------------------------------------------
// Timing and pattern
// ----------------------------------------------------------------
`define SLF_LOS_QUIET_BITS 128
`define SLF_LOS_WIN_BITS   128
`define SLF_LOS_CLR_TRANS  16
`define SLF_SLOW_RATIO     4
`define SLF_BITS_PER_BYTE  8
`define SLF_FRAME_PATTERN  48'hf6f6f6282828
`define SLF_RESP_OKAY      2'h0
`define SLF_RESP_SLVERR    2'h2

`endif

/* slf_pkg.sv */
// Types for the receive loss, framing and byte alignment block.
// Assumes slf_regs.svh sits in the include path.
`include "slf_regs.svh"
package slf_pkg;

  // Control register, software written
  typedef struct packed {
    logic rate_high;
    logic remote_serial_loopback;
    logic analog_local_loopback;
    logic digital_local_loopback;
    logic internal_loss_disable;
  } slf_ctrl_s;

  // Status register, read only
  typedef struct packed {
    logic remote_loop_serial_mute;
    logic searching;
    logic rx_muted;
    logic external_loss;
    logic internal_loss_detect;
  } slf_status_s;

endpackage

/* slf_rx_align.sv */
// Receive back end: loss detect, muting, frame search and byte assembly.
// Assumes one serial bit per clock at high rate, one per four at low rate,
// inputs synchronous to i_clk, AXI4-Lite master per the published protocol.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "slf_regs.svh"
module slf_rx_align
#(
  parameter int LOS_QUIET_BITS = `SLF_LOS_QUIET_BITS,
  parameter int LOS_WIN_BITS   = `SLF_LOS_WIN_BITS,
  parameter int LOS_CLR_TRANS  = `SLF_LOS_CLR_TRANS
)
(
  input  wire logic        i_clk,             // System clock
  input  wire logic        i_rst,             // Synchronous reset, active high
  input  wire logic        i_rx_serial,       // Recovered serial data bit
  input  wire logic        i_external_loss_n, // External loss, active low
  input  wire logic        i_out_of_frame,    // Framer search request
  output logic [7:0]       o_rx_parallel_out, // Parallel receive byte
  output logic             o_rx_byte_clock,   // Receive byte clock
  output logic             o_frame_found_pulse, // Frame found, one byte long
  output logic             o_tx_loop_bit,     // Remote loopback bit to transmit
  output logic             o_tx_loop_valid,   // Remote loopback bit strobe
  input  wire logic [7:0]  i_awaddr,          // AXI write address
  input  wire logic        i_awvalid,         // AXI write address valid
  output logic             o_awready,         // AXI write address ready
  input  wire logic [31:0] i_wdata,           // AXI write data
  input  wire logic [3:0]  i_wstrb,           // AXI write strobes
  input  wire logic        i_wvalid,          // AXI write data valid
  output logic             o_wready,          // AXI write data ready
  output logic [1:0]       o_bresp,           // AXI write response
  output logic             o_bvalid,          // AXI write response valid
  input  wire logic        i_bready,          // AXI write response ready
  input  wire logic [7:0]  i_araddr,          // AXI read address
  input  wire logic        i_arvalid,         // AXI read address valid
  output logic             o_arready,         // AXI read address ready
  output logic [31:0]      o_rdata,           // AXI read data
  output logic [1:0]       o_rresp,           // AXI read response
  output logic             o_rvalid,          // AXI read data valid
  input  wire logic        i_rready           // AXI read data ready
);
  import slf_pkg::*;

  localparam int QW = $clog2(LOS_QUIET_BITS + 2);
  localparam int CW = $clog2(LOS_WIN_BITS + 1);

  if (LOS_CLR_TRANS < 1 || LOS_CLR_TRANS > LOS_WIN_BITS || LOS_QUIET_BITS < 1 || LOS_WIN_BITS < 2)
  begin : g_bad_params
    $error("slf_rx_align: loss parameters out of range");
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  slf_ctrl_s   ctrl_q;
  slf_status_s status;
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d, wr_fire;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_d, awready_d, wready_d, rvalid_d, arready_d;
  logic [1:0]  bresp_d, rresp_d;
  logic [31:0] rdata_d;

  always_comb
  begin
    aw_got_d = aw_got_q | (i_awvalid & o_awready);
    w_got_d  = w_got_q | (i_wvalid & o_wready);
    awaddr_d = (i_awvalid & o_awready) ? i_awaddr : awaddr_q;
    wdata_d  = (i_wvalid & o_wready) ? i_wdata : wdata_q;
    wstrb_d  = (i_wvalid & o_wready) ? i_wstrb : wstrb_q;
    bvalid_d = o_bvalid & ~i_bready;
    bresp_d  = o_bresp;
    wr_fire  = aw_got_d & w_got_d & ~o_bvalid;
    if (wr_fire)
    begin
      bvalid_d = 1'b1;
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bresp_d  = (awaddr_d == `SLF_CTRL_OFFSET) ? `SLF_RESP_OKAY : `SLF_RESP_SLVERR;
    end
    // One write in flight; address and data taken in either order
    awready_d = ~aw_got_d & ~bvalid_d;
    wready_d  = ~w_got_d & ~bvalid_d;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `SLF_RESP_OKAY;
    end
    else
    begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      o_awready <= awready_d;
      o_wready  <= wready_d;
      o_bvalid  <= bvalid_d;
      o_bresp   <= bresp_d;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      ctrl_q <= slf_ctrl_s'(`SLF_CTRL_RESET);
    else if (wr_fire && awaddr_d == `SLF_CTRL_OFFSET && wstrb_d[0])
      ctrl_q <= slf_ctrl_s'(wdata_d[`SLF_CTRL_WIDTH-1:0]);
  end

  always_comb
  begin
    rvalid_d = o_rvalid & ~i_rready;
    rdata_d  = o_rdata;
    rresp_d  = o_rresp;
    if (i_arvalid && o_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d  = `SLF_RESP_OKAY;
      if (i_araddr == `SLF_CTRL_OFFSET)
        rdata_d = {{(32-`SLF_CTRL_WIDTH){1'b0}}, ctrl_q};
      else if (i_araddr == `SLF_STATUS_OFFSET)
        rdata_d = {{(32-`SLF_STATUS_WIDTH){1'b0}}, status};
      else
      begin
        rdata_d = 32'h0000_0000;
        rresp_d = `SLF_RESP_SLVERR;
      end
    end
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `SLF_RESP_OKAY;
    end
    else
    begin
      o_arready <= arready_d;
      o_rvalid  <= rvalid_d;
      o_rdata   <= rdata_d;
      o_rresp   <= rresp_d;
    end
  end

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  logic [1:0] bit_div_q;
  logic       bit_en;

  // Low rate is a quarter of high rate, so a bit lands every fourth clock
  assign bit_en = ctrl_q.rate_high | (bit_div_q == 2'(`SLF_SLOW_RATIO - 1)); // RULE19

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      bit_div_q <= 2'h0;
    else
      bit_div_q <= bit_div_q + 2'h1;
  end

  // ----------------------------------------------------------------
  // Internal loss detector
  // ----------------------------------------------------------------
  logic                    prev_bit_q, trans, int_los_q, ext_los;
  logic [QW-1:0]           quiet_cnt_q;
  logic [CW-1:0]           trans_cnt_q;
  logic [LOS_WIN_BITS-1:0] trans_hist_q;

  assign trans   = bit_en & (i_rx_serial ^ prev_bit_q);
  assign ext_los = ~i_external_loss_n; // RULE4

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      prev_bit_q   <= 1'b0;
      quiet_cnt_q  <= '0;
      trans_cnt_q  <= '0;
      trans_hist_q <= '0;
    end
    else if (bit_en)
    begin
      prev_bit_q   <= i_rx_serial;
      trans_hist_q <= {trans_hist_q[LOS_WIN_BITS-2:0], trans};
      // Sliding window count: add newest, drop the one leaving
      trans_cnt_q  <= trans_cnt_q + CW'(trans) - CW'(trans_hist_q[LOS_WIN_BITS-1]); // RULE2
      if (trans)
        quiet_cnt_q <= '0;
      else if (quiet_cnt_q <= QW'(LOS_QUIET_BITS))
        quiet_cnt_q <= quiet_cnt_q + QW'(1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      int_los_q <= 1'b0;
    else if (ctrl_q.internal_loss_disable)
      int_los_q <= 1'b0; // RULE3
    else if (!int_los_q && quiet_cnt_q > QW'(LOS_QUIET_BITS))
      int_los_q <= 1'b1; // RULE1
    else if (int_los_q && trans_cnt_q >= CW'(LOS_CLR_TRANS))
      int_los_q <= 1'b0; // RULE2
  end

  // ----------------------------------------------------------------
  // Muting
  // ----------------------------------------------------------------
  logic rx_mute, loop_mute;

  // Disable only reaches int_los_q; external loss still mutes with the disable set
  assign rx_mute   = (int_los_q | ext_los) &
                     ~(ctrl_q.digital_local_loopback | ctrl_q.analog_local_loopback); // RULE5 RULE6 RULE9
  assign loop_mute = int_los_q | ext_los; // RULE7 RULE8 RULE9

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_tx_loop_valid <= 1'b0;
      o_tx_loop_bit   <= 1'b0;
    end
    else
    begin
      // Only the looped path sees this mute
      o_tx_loop_valid <= ctrl_q.remote_serial_loopback & bit_en; // RULE10
      o_tx_loop_bit   <= ctrl_q.remote_serial_loopback & bit_en & ~loop_mute & i_rx_serial; // RULE7 RULE8
    end
  end

  // ----------------------------------------------------------------
  // Frame search and byte assembly
  // ----------------------------------------------------------------
  logic [47:0] hist_q;
  logic [2:0]  bit_cnt_q, bit_cnt_d;
  logic        match_now, byte_done;

  assign match_now = i_out_of_frame & bit_en &
                     ({hist_q[46:0], i_rx_serial} == `SLF_FRAME_PATTERN); // RULE11 RULE12 RULE16
  assign byte_done = bit_en & ((bit_cnt_q == 3'h7) | match_now); // RULE18

  always_comb
  begin
    bit_cnt_d = bit_cnt_q;
    if (match_now)
      bit_cnt_d = 3'h0; // RULE13
    else if (bit_en)
      bit_cnt_d = bit_cnt_q + 3'h1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      hist_q    <= 48'h0000_0000_0000; // RULE23
      bit_cnt_q <= 3'h0;
    end
    else
    begin
      if (bit_en)
        hist_q <= {hist_q[46:0], i_rx_serial};
      bit_cnt_q <= bit_cnt_d; // RULE16
    end
  end

  // Free running from the bit counter, so it never stops on loss
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rx_byte_clock <= 1'b0;
    else
      o_rx_byte_clock <= (bit_cnt_d >= 3'h4); // RULE20 RULE21 RULE22
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rx_parallel_out <= 8'h00;
    else if (rx_mute)
      o_rx_parallel_out <= 8'h00; // RULE5
    else if (byte_done)
      o_rx_parallel_out <= {hist_q[6:0], i_rx_serial}; // RULE13 RULE18 RULE20
  end

  // Realignment shortens one byte clock if it is high, stretches it if low; framer must tolerate that glitch
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_frame_found_pulse <= 1'b0; // RULE23
    else if (byte_done)
      o_frame_found_pulse <= match_now; // RULE14 RULE15
  end

  assign status = '{remote_loop_serial_mute: ctrl_q.remote_serial_loopback & loop_mute,
                    searching:               i_out_of_frame,
                    rx_muted:                rx_mute,
                    external_loss:           ext_los,
                    internal_loss_detect:    int_los_q};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_los_declare: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
    (!ctrl_q.internal_loss_disable && quiet_cnt_q > QW'(LOS_QUIET_BITS)) |=> int_los_q)
    else $error("internal loss not declared after quiet period");

  chk_los_clear: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
    (int_los_q && trans_cnt_q >= CW'(LOS_CLR_TRANS)) |=> !int_los_q)
    else $error("internal loss not cleared after enough transitions");

  chk_los_disable: assert property (@(posedge i_clk) disable iff (i_rst) // RULE3
    ctrl_q.internal_loss_disable |=> !int_los_q)
    else $error("internal loss set while detector disabled");

  chk_rx_mute_zero: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
    ((int_los_q || !i_external_loss_n) && !ctrl_q.digital_local_loopback
      && !ctrl_q.analog_local_loopback) |=> o_rx_parallel_out == 8'h00)
    else $error("parallel output not muted during loss");

  chk_loop_mute: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
    (ctrl_q.remote_serial_loopback && bit_en && !i_external_loss_n)
      |=> (o_tx_loop_valid && !o_tx_loop_bit))
    else $error("looped data not muted on external loss");

  chk_frame_pulse: assert property (@(posedge i_clk) disable iff (i_rst) // RULE14
    match_now |=> (o_frame_found_pulse && bit_cnt_q == 3'h0 && !o_rx_byte_clock))
    else $error("frame pulse missing after pattern match");

  chk_pulse_length: assert property (@(posedge i_clk) disable iff (i_rst) // RULE15
    (o_frame_found_pulse && byte_done && !match_now) |=> !o_frame_found_pulse)
    else $error("frame pulse longer than one byte clock");

  chk_no_search: assert property (@(posedge i_clk) disable iff (i_rst) // RULE16
    (!i_out_of_frame && bit_en) |=> bit_cnt_q == $past(bit_cnt_q) + 3'h1)
    else $error("byte boundary moved while search disabled");

  chk_byte_launch: assert property (@(posedge i_clk) disable iff (i_rst) // RULE20
    (byte_done && !rx_mute) |=> ($fell(o_rx_byte_clock) || !$past(o_rx_byte_clock)))
    else $error("byte not launched at byte clock fall");

endmodule

/* slf_framer_model.sv */
// Framer-side model: drives out-of-frame from what it sees on the receive side.
// Assumes the frame pulse is registered on the system clock.
`timescale 1ns/10ps
module slf_framer_model
(
  input  wire logic i_clk,    // System clock
  input  wire logic i_rst,    // Synchronous reset
  input  wire logic i_resync, // Start a frame search
  input  wire logic i_keep,   // Stay in search after a pulse
  input  wire logic i_pulse,  // Frame found
  output logic      o_oof     // Out-of-frame to the block
);
  logic pulse_q;
  logic oof_q;

  assign o_oof = oof_q;

  always_ff @(posedge i_clk)
  begin
    pulse_q <= i_pulse;
    if (i_rst)
      oof_q <= 1'b0;
    else if (i_resync)
      oof_q <= 1'b1;
    // Drop after the pulse ends so its full width stays observable
    else if (pulse_q && !i_pulse && !i_keep)
      oof_q <= 1'b0;
  end
endmodule

/* slf_rx_align_test.sv */
// Self-checking bench for the receive loss, framing and byte block.
// Assumes slf_regs.svh, slf_pkg.sv, slf_rx_align.sv and slf_framer_model.sv.
`timescale 1ns/10ps
`include "slf_regs.svh"
module slf_rx_align_test;
  import slf_pkg::*;
  logic        clk, rst, rx, ext_n, resync, keep, out_of_frame;
  logic [7:0]  awaddr, araddr, rx_byte, last_byte, pulse_byte;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, bclk, pulse, lbit, lvalid, bclk_p, pulse_p;
  int          gap, last_gap, plen, last_plen, pulses, ones, n, hold;
  int          miscompares, samples_checked;

  slf_rx_align #(.LOS_QUIET_BITS(16), .LOS_WIN_BITS(16), .LOS_CLR_TRANS(4)) DUT (
    .i_clk(clk), .i_rst(rst), .i_rx_serial(rx), .i_external_loss_n(ext_n),
    .i_out_of_frame(out_of_frame), .o_rx_parallel_out(rx_byte), .o_rx_byte_clock(bclk),
    .o_frame_found_pulse(pulse), .o_tx_loop_bit(lbit), .o_tx_loop_valid(lvalid),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready));

  slf_framer_model framer (.i_clk(clk), .i_rst(rst), .i_resync(resync), .i_keep(keep),
    .i_pulse(pulse), .o_oof(out_of_frame));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Receive-side monitor
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    bclk_p <= bclk;
    pulse_p <= pulse;
    gap <= (bclk_p && !bclk) ? 1 : gap + 1;
    plen <= (pulse && !pulse_p) ? 1 : plen + 1;
    if (bclk_p && !bclk)
    begin
      last_byte <= rx_byte;
      last_gap <= gap;
    end
    if (pulse && !pulse_p)
    begin
      pulses <= pulses + 1;
      pulse_byte <= rx_byte;
    end
    if (!pulse && pulse_p)
      last_plen <= plen;
    if (lvalid)
      ones <= ones + lbit;
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus tasks
  // ----------------------------------------------------------------
  task automatic send(input logic [63:0] v, input int nb);
    for (int i = nb - 1; i >= 0; i--)
    begin
      rx <= v[i];
      repeat (hold) @(posedge clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rd = rdata;
    rready <= 1'b0;
    check({rresp, rd}, {er, exp});
  endtask

  // Idle cycles count as strobes, so alignment is rebuilt after each wait
  task automatic run_frame(input int np);
    keep <= (np == 2);
    resync <= 1'b1;
    @(posedge clk);
    resync <= 1'b0;
    send(32'h55555555, 32);
    n = pulses;
    if (np == 2)
    begin
      rchk(`SLF_STATUS_OFFSET, 32'h08, `SLF_RESP_OKAY);
      send({`SLF_FRAME_PATTERN, 16'h5555}, 64);
      keep <= 1'b0;
    end
    send({`SLF_FRAME_PATTERN, 16'hc35a}, 64);
    repeat (3 * hold) @(posedge clk);
    check(pulses - n, np);
    check(pulse_byte, 8'h28);
    check(last_plen, 8 * hold);
    check(last_byte, 8'h5a);
    check(last_gap, 8 * hold);
  endtask

  task automatic loops(input int exp);
    send(8'h00, 8);
    n = ones;
    send(32'hf0f0f0f0, 32);
    repeat (3) @(posedge clk);
    check(ones - n, exp);
  endtask

  task automatic quiet_ones(input int exp);
    repeat (3) @(posedge clk);
    n = ones;
    repeat (20) @(posedge clk);
    check(ones - n, exp);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end

  initial
  begin
    {rst, ext_n, hold} = {1'b1, 1'b1, 32'd1};
    {rx, resync, keep, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check({pulse, rx_byte}, 9'h000);
    rchk(`SLF_CTRL_OFFSET, `SLF_CTRL_RESET, `SLF_RESP_OKAY);
    rchk(8'h08, 32'h0, `SLF_RESP_SLVERR);
    wr(`SLF_STATUS_OFFSET, 32'h1f);
    check(resp, `SLF_RESP_SLVERR);
    rchk(`SLF_CTRL_OFFSET, `SLF_CTRL_RESET, `SLF_RESP_OKAY);
    run_frame(2);
    n = pulses;
    send({`SLF_FRAME_PATTERN, 5'b10101, 8'h5a}, 61);
    repeat (3) @(posedge clk);
    check(pulses - n, 0);
    check(last_byte, 8'h5a);
    repeat (40) @(posedge clk);
    check(gap <= 8, 1'b1);
    rchk(`SLF_STATUS_OFFSET, 32'h05, `SLF_RESP_OKAY);
    send(32'h55555555, 32);
    rchk(`SLF_STATUS_OFFSET, 32'h00, `SLF_RESP_OKAY);
    ext_n <= 1'b0;
    send(32'h55555555, 32);
    repeat (3) @(posedge clk);
    check(last_byte, 8'h00);
    rchk(`SLF_STATUS_OFFSET, 32'h06, `SLF_RESP_OKAY);
    for (int k = 1; k < 3; k++)
    begin
      wr(`SLF_CTRL_OFFSET, 32'h10 | (1 << k));
      send(32'h55555555, 32);
      repeat (3) @(posedge clk);
      check(last_byte ^ {last_byte[0], last_byte[7:1]}, 8'hff);
    end
    wr(`SLF_CTRL_OFFSET, 32'h11);
    send(32'h55555555, 32);
    repeat (3) @(posedge clk);
    check(last_byte, 8'h00);
    ext_n <= 1'b1;
    repeat (40) @(posedge clk);
    rchk(`SLF_STATUS_OFFSET, 32'h00, `SLF_RESP_OKAY);
    wr(`SLF_CTRL_OFFSET, 32'h18);
    send(32'h55555555, 32);
    loops(16);
    ext_n <= 1'b0;
    loops(0);
    ext_n <= 1'b1;
    send(8'h0f, 8);
    repeat (40) @(posedge clk);
    quiet_ones(0);
    rchk(`SLF_STATUS_OFFSET, 32'h15, `SLF_RESP_OKAY);
    wr(`SLF_CTRL_OFFSET, 32'h19);
    quiet_ones(20);
    ext_n <= 1'b0;
    quiet_ones(0);
    ext_n <= 1'b1;
    // Quarter-rate bits are held four clocks so each strobe sees one bit
    wr(`SLF_CTRL_OFFSET, 32'h00);
    hold = 4;
    run_frame(1);
    summarize();
  end
endmodule
